// >>> logic/ride_core.sv
// Decode and execute core for 16-bit instruction words, with its AXI4-Lite
// register slave.
// Assumes program memory on mclk presents pm_data for pm_addr with pm_valid.
//
// Function
// - AND, OR, XOR accumulator with source; update only sign and zero.
// - Complement or negate accumulator; update sign and zero.
// - Arithmetic left shift by 1, 2 or 4; update carry, sign, zero.
// - Signed right shift by 1, 2 or 4; keep sign; update carry, zero.
// - Logical right shift by one, zero in; update carry, sign, zero.
// - Rotate left or right without carry; update only sign.
// - Rotate through carry; update carry, sign and zero.
// - Clear, set or invert carry; no other flag changes.
// - Copy accumulator bit to carry, or carry to bit with sign, zero.
// - AND, OR, XOR carry with accumulator bit into carry only.
// - Set or clear one of four flags (carry, zero, sign, equal) of the fixed flag destination.
// - Add and add with carry; update carry, sign, zero, overflow.
// - Subtract and subtract with borrow; update carry, sign, zero, overflow.
// - Unconditional jump, relative or absolute; no flag changes.
// - Conditional jumps on carry, no carry, zero, nonzero, sign.
// - Equal and not-equal jumps exist only in immediate form.
// - Decrement selected loop counter; branch while it stays nonzero.
// - Call pushes next address onto pre-incremented stack, then jumps.
// - Return pops the stack top, always or on a condition.
// - Return from interrupt also clears the in-service flag when taken, unless a same-cycle status write sets it.
// - Byte swap of the accumulator; update sign.
`timescale 1ns/100ps
`default_nettype none
module ride_core (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  output logic [15:0]      pm_addr,
  input  wire logic [15:0] pm_data,
  input  wire logic        pm_valid,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  function automatic logic cond_met(input logic [2:0] cc, input logic c, z, s, e);
    case (cc)
      3'h0:    cond_met = 1'b1;
      3'h2:    cond_met = c;
      3'h6:    cond_met = !c;
      3'h1:    cond_met = z;
      3'h5:    cond_met = !z;
      3'h3:    cond_met = e;
      3'h7:    cond_met = !e;
      default: cond_met = s;
    endcase
  endfunction : cond_met

  function automatic logic [15:0] merge16(input logic [15:0] o, n, input logic [1:0] st);
    merge16 = {st[1] ? n[15:8] : o[15:8], st[0] ? n[7:0] : o[7:0]};
  endfunction : merge16

  logic [15:0] acc_r [16];
  logic [15:0] stack_r [16];
  logic [15:0] lc_r [2];
  logic [15:0] ip_r;
  logic [3:0]  sp_r;
  logic [3:0]  ap_r;
  logic        run_r;
  logic        c_r, z_r, s_r, e_r, ov_r, ins_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [7:0]  wa;
  logic        wr_fire, wr_ctrl, wr_stat, wr_ip, wr_lc0, wr_lc1;
  logic        exec, f;
  logic [2:0]  op;
  logic [3:0]  grp, nib, sub;
  logic [7:0]  src;
  logic [15:0] acc_act, src_val, target, res;
  logic [16:0] sum;
  logic        acc_we, upd_s, upd_z, push, lc_we, lc_idx, ins_clr;
  logic        c_nxt, z_nxt, s_nxt, e_nxt, ov_nxt;
  logic [15:0] ip_nxt, lc_wd;
  logic [3:0]  sp_nxt;

  assign pm_addr = ip_r;
  assign exec    = run_r && pm_valid;
  assign f       = pm_data[15];
  assign op      = pm_data[14:12];
  assign grp     = pm_data[11:8];
  assign src     = pm_data[7:0];
  assign sub     = pm_data[7:4];
  assign nib     = pm_data[3:0];
  assign acc_act = acc_r[ap_r];
  // Unmapped register sources read as zero rather than stalling the core.
  assign src_val = !f ? {8'h00, src} : (nib == ride_pkg::SRC_ACC) ? acc_r[sub] : 16'h0000;
  assign target  = f ? src_val : 16'(ip_r + {{8{src[7]}}, src});

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    res = acc_act; acc_we = 1'b0; upd_s = 1'b0; upd_z = 1'b0; sum = 17'h00000;
    c_nxt = c_r; z_nxt = z_r; s_nxt = s_r; e_nxt = e_r; ov_nxt = ov_r;
    ip_nxt = 16'(ip_r + 16'h0001); sp_nxt = sp_r; push = 1'b0;
    lc_we = 1'b0; lc_idx = op[0]; lc_wd = lc_r[op[0]]; ins_clr = 1'b0;
    if (exec)
    begin
      case (grp)
        ride_pkg::GRP_ALU:
          if (f && nib == ride_pkg::NIB_SPEC)
          begin
            case (op)
              ride_pkg::OP_UNARY:
              begin
                acc_we = 1'b1;
                case (sub)
                  ride_pkg::U_CPL:  begin res = ~acc_act; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_NEG:  begin res = 16'(~acc_act + 16'h0001); upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_SLA:  begin res = {acc_act[14:0], 1'b0}; c_nxt = acc_act[15]; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_SLA2: begin res = {acc_act[13:0], 2'h0}; c_nxt = acc_act[14]; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_SLA4: begin res = {acc_act[11:0], 4'h0}; c_nxt = acc_act[12]; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_SRA:  begin res = {acc_act[15], acc_act[15:1]}; c_nxt = acc_act[0]; upd_z = 1'b1; end
                  ride_pkg::U_SRA2: begin res = {{2{acc_act[15]}}, acc_act[15:2]}; c_nxt = acc_act[1]; upd_z = 1'b1; end
                  ride_pkg::U_SRA4: begin res = {{4{acc_act[15]}}, acc_act[15:4]}; c_nxt = acc_act[3]; upd_z = 1'b1; end
                  ride_pkg::U_SR:   begin res = {1'b0, acc_act[15:1]}; c_nxt = acc_act[0]; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_RL:   begin res = {acc_act[14:0], acc_act[15]}; upd_s = 1'b1; end
                  ride_pkg::U_RR:   begin res = {acc_act[0], acc_act[15:1]}; upd_s = 1'b1; end
                  ride_pkg::U_RLC:  begin res = {acc_act[14:0], c_r}; c_nxt = acc_act[15]; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_RRC:  begin res = {c_r, acc_act[15:1]}; c_nxt = acc_act[0]; upd_s = 1'b1; upd_z = 1'b1; end
                  ride_pkg::U_XCH:  begin res = {acc_act[7:0], acc_act[15:8]}; upd_s = 1'b1; end
                  default:          acc_we = 1'b0;
                endcase
              end
              ride_pkg::OP_CARRY:
                case (sub)
                  ride_pkg::C_CLR: c_nxt = 1'b0;
                  ride_pkg::C_SET: c_nxt = 1'b1;
                  ride_pkg::C_INV: c_nxt = !c_r;
                  default:         c_nxt = c_r;
                endcase
              ride_pkg::OP_CBIT: c_nxt = acc_act[sub];
              ride_pkg::OP_BITC:
              begin
                res[sub] = c_r; acc_we = 1'b1; upd_s = 1'b1; upd_z = 1'b1;
              end
              ride_pkg::OP_AND: c_nxt = c_r & acc_act[sub];
              ride_pkg::OP_OR:  c_nxt = c_r | acc_act[sub];
              ride_pkg::OP_XOR: c_nxt = c_r ^ acc_act[sub];
              default:          c_nxt = c_r;
            endcase
          end
          else
          begin
            case (op)
              ride_pkg::OP_AND: begin res = acc_act & src_val; acc_we = 1'b1; upd_s = 1'b1; upd_z = 1'b1; end
              ride_pkg::OP_OR:  begin res = acc_act | src_val; acc_we = 1'b1; upd_s = 1'b1; upd_z = 1'b1; end
              ride_pkg::OP_XOR: begin res = acc_act ^ src_val; acc_we = 1'b1; upd_s = 1'b1; upd_z = 1'b1; end
              ride_pkg::OP_ADD, ride_pkg::OP_ADD_WITH_CARRY:
              begin
                sum = {1'b0, acc_act} + {1'b0, src_val} + {16'h0000, op[1] & c_r};
                ov_nxt = (acc_act[15] == src_val[15]) && (sum[15] != acc_act[15]);
              end
              ride_pkg::OP_SUB, ride_pkg::OP_SUB_WITH_BORROW:
              begin
                sum = {1'b0, acc_act} - {1'b0, src_val} - {16'h0000, op[1] & c_r};
                ov_nxt = (acc_act[15] != src_val[15]) && (sum[15] != acc_act[15]);
              end
              default: acc_we = 1'b0;
            endcase
            if (op[2])
            begin
              res = sum[15:0]; c_nxt = sum[16]; acc_we = 1'b1; upd_s = 1'b1; upd_z = 1'b1;
            end
          end
        ride_pkg::GRP_JMP:
          if (f && (src == ride_pkg::RET_LO || src == ride_pkg::RETURN_FROM_IRQ_LO))
          begin
            if (cond_met(op, c_r, z_r, s_r, e_r))
            begin
              ip_nxt = stack_r[sp_r]; sp_nxt = 4'(sp_r - 4'h1);
              ins_clr = src[7];
            end
          end
          // Equal tests with the top bit set are not jumps and fall through.
          else if (!(f && op[1:0] == 2'b11) && cond_met(op, c_r, z_r, s_r, e_r))
            ip_nxt = target;
        ride_pkg::GRP_BR:
          if (op[2:1] == 2'b10)
          begin
            lc_we = 1'b1; lc_wd = 16'(lc_r[op[0]] - 16'h0001);
            if (lc_wd != 16'h0000)
              ip_nxt = target;
          end
          else if (op == ride_pkg::OP_CALL)
          begin
            push = 1'b1; sp_nxt = 4'(sp_r + 4'h1); ip_nxt = target;
          end
        default:
          if (f && nib == ride_pkg::NIB_BIT && pm_data[14:8] == ride_pkg::PSF_DST)
            case (pm_data[6:4])
              3'h0:    c_nxt = pm_data[7];
              3'h1:    z_nxt = pm_data[7];
              3'h2:    s_nxt = pm_data[7];
              3'h3:    e_nxt = pm_data[7];
              default: e_nxt = e_r;
            endcase
      endcase
      if (acc_we && upd_s)
        s_nxt = res[15];
      if (acc_we && upd_z)
        z_nxt = (res == 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
      begin
        acc_r[i] <= 16'h0000;
        stack_r[i] <= 16'h0000;
      end
    end
    else
    begin
      if (acc_we)
        acc_r[ap_r] <= res;
      if (push)
        stack_r[sp_nxt] <= 16'(ip_r + 16'h0001);
    end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      {c_r, z_r, s_r, e_r, ov_r, sp_r} <= 9'h000;
    else
    begin
      {c_r, z_r, s_r, e_r, ov_r} <= {c_nxt, z_nxt, s_nxt, e_nxt, ov_nxt};
      sp_r <= sp_nxt;
    end

  // A bus write to the pointer or counters overrides the instruction in flight.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ip_r <= ride_pkg::IP_RST;
      lc_r[0] <= 16'h0000;
      lc_r[1] <= 16'h0000;
    end
    else
    begin
      ip_r <= wr_ip ? merge16(ip_r, wdata_r[15:0], wstrb_r[1:0]) : exec ? ip_nxt : ip_r;
      if (wr_lc0)
        lc_r[0] <= merge16(lc_r[0], wdata_r[15:0], wstrb_r[1:0]);
      else if (lc_we && !lc_idx)
        lc_r[0] <= lc_wd;
      if (wr_lc1)
        lc_r[1] <= merge16(lc_r[1], wdata_r[15:0], wstrb_r[1:0]);
      else if (lc_we && lc_idx)
        lc_r[1] <= lc_wd;
    end

  // Software setting the in-service flag beats a same-cycle clear.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      ins_r <= 1'b0;
    else if (wr_stat && wstrb_r[0] && wdata_r[ride_pkg::F_INS])
      ins_r <= 1'b1;
    else if (ins_clr)
      ins_r <= 1'b0;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      run_r <= 1'b0;
      ap_r <= ride_pkg::AP_RST;
    end
    else if (wr_ctrl && wstrb_r[0])
    begin
      run_r <= wdata_r[ride_pkg::CT_RUN];
      ap_r <= wdata_r[ride_pkg::CT_AP +: 4];
    end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_r && w_got_r;
  assign wa      = awaddr_r & 8'hFC;
  assign wr_ctrl = wr_fire && wa == ride_pkg::REG_CTRL;
  assign wr_stat = wr_fire && wa == ride_pkg::REG_STAT;
  assign wr_ip   = wr_fire && wa == ride_pkg::REG_IP;
  assign wr_lc0  = wr_fire && wa == ride_pkg::REG_LC0;
  assign wr_lc1  = wr_fire && wa == ride_pkg::REG_LC1;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      {aw_got_r, w_got_r, s_axi_bvalid} <= 3'h0;
      awaddr_r <= 8'h00; wdata_r <= 32'h00000000; wstrb_r <= 4'h0; s_axi_bresp <= ride_pkg::RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1; awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1; wdata_r <= s_axi_wdata; wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0; w_got_r <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa <= ride_pkg::REG_LC1) ? ride_pkg::RESP_OK : ride_pkg::RESP_DEC;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h00000000; s_axi_rresp <= ride_pkg::RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1; s_axi_rresp <= ride_pkg::RESP_OK;
      case (s_axi_araddr & 8'hFC)
        ride_pkg::REG_CTRL: s_axi_rdata <= {24'h000000, ap_r, 3'h0, run_r};
        ride_pkg::REG_STAT: s_axi_rdata <= {26'h0000000, ins_r, ov_r, e_r, s_r, z_r, c_r};
        ride_pkg::REG_IP:   s_axi_rdata <= {16'h0000, ip_r};
        ride_pkg::REG_ACC:  s_axi_rdata <= {16'h0000, acc_act};
        ride_pkg::REG_LC0:  s_axi_rdata <= {16'h0000, lc_r[0]};
        ride_pkg::REG_LC1:  s_axi_rdata <= {16'h0000, lc_r[1]};
        default:
        begin
          s_axi_rdata <= 32'h00000000; s_axi_rresp <= ride_pkg::RESP_DEC;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic spec, plain;
  assign spec  = exec && !wr_fire && grp == ride_pkg::GRP_ALU && f && nib == ride_pkg::NIB_SPEC;
  assign plain = exec && !wr_fire && grp == ride_pkg::GRP_ALU && !(f && nib == ride_pkg::NIB_SPEC);
  sequence s_call;
    exec && !wr_fire && grp == ride_pkg::GRP_BR && op == ride_pkg::OP_CALL;
  endsequence
  sequence s_return_from_irq_taken;
    exec && grp == ride_pkg::GRP_JMP && f && src == ride_pkg::RETURN_FROM_IRQ_LO && cond_met(op, c_r, z_r, s_r, e_r);
  endsequence
  a_logic_flags_kept: assert property (plain && op == ride_pkg::OP_AND |=> $stable(c_r) && $stable(ov_r))
    else $error("Logic op changed carry or overflow.");
  a_cpl_result: assert property (spec && op == 3'h0 && sub == ride_pkg::U_CPL |=> acc_act == ~$past(acc_act))
    else $error("Complement result wrong.");
  a_sla_carry: assert property (spec && op == 3'h0 && sub == ride_pkg::U_SLA |=> c_r == $past(acc_act[15]))
    else $error("Shift left carry wrong.");
  a_sra_sign_kept: assert property (spec && op == 3'h0 && sub == ride_pkg::U_SRA4 |=> acc_act[15] == $past(acc_act[15]) && $stable(s_r))
    else $error("Signed shift lost sign.");
  a_sr_zero_msb: assert property (spec && op == 3'h0 && sub == ride_pkg::U_SR |=> !acc_act[15] && !s_r)
    else $error("Logical shift msb not zero.");
  a_rot_flags: assert property (spec && op == 3'h0 && sub == ride_pkg::U_RL |=> $stable(c_r) && $stable(z_r))
    else $error("Plain rotate touched carry or zero.");
  a_carry_set: assert property (spec && op == ride_pkg::OP_CARRY && sub == ride_pkg::C_SET |=> c_r && $stable(z_r))
    else $error("Carry set failed.");
  a_loop_dec: assert property (exec && !wr_fire && grp == ride_pkg::GRP_BR && op[2:1] == 2'b10 && !op[0]
    |=> lc_r[0] == 16'($past(lc_r[0]) - 16'h0001))
    else $error("Loop counter not decremented.");
  a_call_push: assert property (s_call |=> sp_r == 4'($past(sp_r) + 4'h1) ##0 stack_r[sp_r] == 16'($past(ip_r) + 16'h0001))
    else $error("Call push wrong.");
  a_return_from_irq_clears: assert property (s_return_from_irq_taken ##0 !(wr_stat && wdata_r[ride_pkg::F_INS]) |=> !ins_r)
    else $error("In-service flag not cleared.");
endmodule : ride_core
`default_nettype wire

// >>> inc/ride_pkg.sv
// Constants for the instruction decode and execute core.
// Assumes a 16-bit accumulator core and an AXI4-Lite register bus.
package ride_pkg;
  localparam logic [15:0] IP_RST   = 16'h0000;
  localparam logic [3:0]  AP_RST   = 4'h0;
  localparam logic [3:0]  GRP_ALU  = 4'hA;
  localparam logic [3:0]  GRP_JMP  = 4'hC;
  localparam logic [3:0]  GRP_BR   = 4'hD;
  localparam logic [3:0]  NIB_SPEC = 4'hA;
  localparam logic [3:0]  NIB_BIT  = 4'h7;
  localparam logic [3:0]  SRC_ACC  = 4'hA;
  localparam logic [7:0]  RET_LO   = 8'h0D;
  localparam logic [7:0]  RETURN_FROM_IRQ_LO  = 8'h8D;
  localparam logic [6:0]  PSF_DST  = 7'h48;
  localparam logic [2:0]  OP_UNARY = 3'h0;
  localparam logic [2:0]  OP_AND   = 3'h1;
  localparam logic [2:0]  OP_OR    = 3'h2;
  localparam logic [2:0]  OP_XOR   = 3'h3;
  localparam logic [2:0]  OP_ADD   = 3'h4;
  localparam logic [2:0]  OP_SUB   = 3'h5;
  localparam logic [2:0]  OP_ADD_WITH_CARRY  = 3'h6;
  localparam logic [2:0]  OP_SUB_WITH_BORROW  = 3'h7;
  localparam logic [2:0]  OP_CARRY = 3'h5;
  localparam logic [2:0]  OP_CBIT  = 3'h6;
  localparam logic [2:0]  OP_BITC  = 3'h7;
  localparam logic [2:0]  OP_CALL  = 3'h3;
  localparam logic [3:0]  U_CPL  = 4'h1;
  localparam logic [3:0]  U_NEG  = 4'h9;
  localparam logic [3:0]  U_SLA  = 4'h2;
  localparam logic [3:0]  U_SLA2 = 4'h3;
  localparam logic [3:0]  U_SLA4 = 4'h6;
  localparam logic [3:0]  U_SRA  = 4'hF;
  localparam logic [3:0]  U_SRA2 = 4'hE;
  localparam logic [3:0]  U_SRA4 = 4'hB;
  localparam logic [3:0]  U_SR   = 4'hA;
  localparam logic [3:0]  U_RL   = 4'h4;
  localparam logic [3:0]  U_RR   = 4'hC;
  localparam logic [3:0]  U_RLC  = 4'h5;
  localparam logic [3:0]  U_RRC  = 4'hD;
  localparam logic [3:0]  U_XCH  = 4'h8;
  localparam logic [3:0]  C_CLR  = 4'h0;
  localparam logic [3:0]  C_SET  = 4'h1;
  localparam logic [3:0]  C_INV  = 4'h2;
  localparam int F_C   = 0;
  localparam int F_Z   = 1;
  localparam int F_S   = 2;
  localparam int F_E   = 3;
  localparam int F_OV  = 4;
  localparam int F_INS = 5;
  localparam int CT_RUN = 0;
  localparam int CT_AP  = 4;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IP   = 8'h08;
  localparam logic [7:0] REG_ACC  = 8'h0C;
  localparam logic [7:0] REG_LC0  = 8'h10;
  localparam logic [7:0] REG_LC1  = 8'h14;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
endpackage : ride_pkg

// >>> test/ride_pmem.sv
// Program memory model that feeds instruction words to the core.
// Assumes the bench loads nine words through prog; higher addresses hold a jump to self.
`timescale 1ns/100ps
`default_nettype none
module ride_pmem (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         slow,
  input  wire logic [143:0] prog,
  input  wire logic [15:0]  pm_addr,
  output logic [15:0]       pm_data,
  output logic              pm_valid
);
  logic        tick_r;
  logic [15:0] word;
  ////////////////////////////////////////////////////////////
  // A slow memory answers every other cycle and shows inverted data in between,
  // so a core that executes without pm_valid runs the wrong word.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_r <= 1'h0;
    else
      tick_r <= ~tick_r;
  end
  assign word     = (pm_addr < 16'h0009) ? prog[{pm_addr[3:0], 4'h0} +: 16] : 16'h0C00;
  assign pm_valid = !slow || tick_r;
  assign pm_data  = pm_valid ? word : ~word;
endmodule : ride_pmem
`default_nettype wire

// >>> test/ride_core_tb.sv
// Self-checking bench for the decode and execute core.
// Assumes the core's register slave and the ride_pmem program memory model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ride_core_tb;
  typedef struct packed {logic [15:0] a; logic ov; logic s; logic z; logic c;} ride_st_t;
  localparam logic [28:0][15:0] OPS = {16'h8A1A, 16'h8A9A, 16'h8A2A, 16'h8A3A, 16'h8A6A, 16'h8AFA, 16'h8AEA,
    16'h8ABA, 16'h8AAA, 16'h8A4A, 16'h8ACA, 16'h8A5A, 16'h8ADA, 16'h8A8A, 16'hDA0A, 16'hDA1A, 16'hDA2A,
    16'hEA0A, 16'hFA0A, 16'h9A0A, 16'hAA0A, 16'hBA0A, 16'h1A00, 16'h2A00, 16'h3A00, 16'h4A00, 16'h5A00,
    16'h6A00, 16'h7A00};
  localparam logic [7:0][7:0] JC = {8'h4C, 8'h7C, 8'h3C, 8'h5C, 8'h1C, 8'h6C, 8'h2C, 8'h0C};
  logic         mclk, rst_n, slow, pm_valid;
  logic [15:0]  pm_addr, pm_data, last;
  logic [143:0] prog;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0]  exp_q[$];
  logic [33:0]  exp_v;
  int           miscompares, comparisons, seed;
  ride_core u_dut (.mclk, .rst_n, .pm_addr, .pm_data, .pm_valid, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ride_pmem u_pm (.mclk, .rst_n, .slow, .prog, .pm_addr, .pm_data, .pm_valid);
  ////////////////////////////////////////////////////////////
  function automatic ride_st_t step(ride_st_t t, logic [15:0] w);
    ride_st_t    n;
    logic [16:0] r;
    logic        alu;
    n = t;
    r = w[12] ? t.a - w[7:0] - (w[13] & t.c) : t.a + w[7:0] + (w[13] & t.c);
    alu = w[15:8] inside {8'h1A, 8'h2A, 8'h3A, 8'h4A, 8'h5A, 8'h6A, 8'h7A, 8'hFA};
    casez (w)
      16'h8A1A: n.a = ~t.a;
      16'h8A9A: n.a = ~t.a + 16'h0001;
      16'h8A2A: {n.c, n.a} = {t.a, 1'h0};
      16'h8A3A: {n.c, n.a} = {t.a[14:0], 2'h0};
      16'h8A6A: {n.c, n.a} = {t.a[12:0], 4'h0};
      16'h8AFA: {n.a, n.c} = {t.a[15], t.a};
      16'h8AEA: {n.a, n.c} = {{2{t.a[15]}}, t.a[15:1]};
      16'h8ABA: {n.a, n.c} = {{4{t.a[15]}}, t.a[15:3]};
      16'h8AAA: {n.a, n.c} = {1'h0, t.a};
      16'h8A4A: n.a = {t.a[14:0], t.a[15]};
      16'h8ACA: n.a = {t.a[0], t.a[15:1]};
      16'h8A5A: {n.c, n.a} = {t.a, t.c};
      16'h8ADA: {n.a, n.c} = {t.c, t.a};
      16'h8A8A: n.a = {t.a[7:0], t.a[15:8]};
      16'hDA0A: n.c = 1'h0;
      16'hDA1A: n.c = 1'h1;
      16'hDA2A: n.c = ~t.c;
      16'hEA?A: n.c = t.a[w[7:4]];
      16'hFA?A: n.a[w[7:4]] = t.c;
      16'h9A?A: n.c = t.c & t.a[w[7:4]];
      16'hAA?A: n.c = t.c | t.a[w[7:4]];
      16'hBA?A: n.c = t.c ^ t.a[w[7:4]];
      16'h1A??: n.a = t.a & w[7:0];
      16'h2A??: n.a = t.a | w[7:0];
      16'h3A??: n.a = t.a ^ w[7:0];
      16'h4A??, 16'h5A??, 16'h6A??, 16'h7A??: {n.c, n.a} = r;
      default: n = t;
    endcase
    if (w[15:8] inside {8'h4A, 8'h5A, 8'h6A, 8'h7A})
      n.ov = w[12] ? (t.a[15] & !r[15]) : (!t.a[15] & r[15]);
    if (alu || (w[15:8] == 8'h8A && !(w[7:4] inside {4'hF, 4'hE, 4'hB})))
      n.s = n.a[15];
    if (alu || (w[15:8] == 8'h8A && !(w[7:4] inside {4'h4, 4'hC, 4'h8})))
      n.z = (n.a == 16'h0000);
    return n;
  endfunction : step
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 100);
    if (!s_axi_bvalid)
      miscompares++;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [33:0] e);
    int n;
    @(posedge mclk);
    exp_q.push_back(e);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 100);
    if (!s_axi_rvalid)
      miscompares++;
    s_axi_rready <= 1'h0;
  endtask : rd
  // Each case rebuilds a full 16-bit accumulator from two random bytes before the operation under test.
  task automatic run_case(input int i);
    logic [15:0] w[9];
    ride_st_t    t;
    logic [7:0]  cv;
    w = '{16'h1A00, {8'h4A, 8'($random(seed))}, 16'h8A8A, {8'h4A, 8'($random(seed))},
      ($random(seed) & 1) ? 16'hDA1A : 16'hDA0A, OPS[i], {JC[i % 8], 8'h02}, 16'h0C00, 16'h0C00};
    if (w[5][15:8] inside {8'h9A, 8'hAA, 8'hBA, 8'hEA, 8'hFA})
      w[5][7:4] = 4'($random(seed));
    if (w[5][7:0] == 8'h00)
      w[5][7:0] = 8'($random(seed));
    t = '0;
    for (int k = 0; k < 6; k++)
      t = step(t, w[k]);
    cv = {t.s, 1'h1, 1'h0, ~t.z, t.z, ~t.c, t.c, 1'h1};
    slow <= 1'($random(seed));
    wr(ride_pkg::REG_CTRL, 32'h0);
    wr(ride_pkg::REG_IP, 32'h0);
    for (int k = 0; k < 9; k++)
      prog[k*16 +: 16] <= w[k];
    wr(ride_pkg::REG_CTRL, 32'h1);
    repeat (20) @(posedge mclk);
    rd(ride_pkg::REG_ACC, {ride_pkg::RESP_OK, 16'h0, t.a});
    rd(ride_pkg::REG_STAT, {ride_pkg::RESP_OK, 27'h0, t.ov, 1'h0, t.s, t.z, t.c});
    rd(ride_pkg::REG_IP, {ride_pkg::RESP_OK, 16'h0, cv[i % 8] ? 16'h0008 : 16'h0007});
    last = t.a;
  endtask : run_case
  // Sets sign, calls a loop that counts LC0 down from 3, then returns from interrupt on sign.
  task automatic run_branch;
    logic [15:0] w[9];
    w = '{16'h1A00, 16'h4A00, 16'hC8A7, 16'h3D02, 16'h0C00, 16'h4D00, 16'hCC8D, 16'h0C00, 16'h0C00};
    slow <= 1'h0;
    wr(ride_pkg::REG_CTRL, 32'h0);
    wr(ride_pkg::REG_IP, 32'h0);
    wr(ride_pkg::REG_LC0, 32'h3);
    wr(ride_pkg::REG_STAT, 32'h20);
    for (int k = 0; k < 9; k++)
      prog[k*16 +: 16] <= w[k];
    wr(ride_pkg::REG_CTRL, 32'h1);
    repeat (20) @(posedge mclk);
    rd(ride_pkg::REG_IP, {ride_pkg::RESP_OK, 32'h4});
    rd(ride_pkg::REG_LC0, {ride_pkg::RESP_OK, 32'h0});
    rd(ride_pkg::REG_STAT, {ride_pkg::RESP_OK, 32'h6});
    last = 16'h0000;
  endtask : run_branch
  task automatic finish_test;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, exp_v)
    end
    if (s_axi_bvalid && s_axi_bready)
      `CHK(s_axi_bresp, ride_pkg::RESP_OK)
  end
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial
  begin
    {rst_n, slow, prog, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    seed = 12124;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    rd(ride_pkg::REG_CTRL, {ride_pkg::RESP_OK, 32'h0});
    rd(ride_pkg::REG_IP, {ride_pkg::RESP_OK, 32'h0});
    rd(8'h18, {ride_pkg::RESP_DEC, 32'h0});
    for (int i = 0; i < 29; i++)
      run_case(i);
    run_branch();
    wr(ride_pkg::REG_ACC, 32'h0000FFFF);
    rd(ride_pkg::REG_ACC, {ride_pkg::RESP_OK, 16'h0, last});
    repeat (2) @(posedge mclk);
    finish_test();
  end
endmodule : ride_core_tb
`default_nettype wire
